// >>> dv/board_ctrl_model.sv
/*
 * Board-side model: reference clocks, oscillator and master reset pulses.
 * Assumes the bench drives the stop and request pins on rising edges of mclk_in.
 */
`timescale 1ns/1ps
module board_ctrl_model
(
   input wire logic mclk_in, // System clock
   input wire logic nrst_in, // Synchronous reset, active low
   input wire logic [3:0] ref_stop_in, // Hold a reference input low
   input wire logic mr_request_in, // Ask for one master reset pulse
   output logic [3:0] ref_clk_out, // Reference clocks
   output logic vco_clk_out, // Oscillator level
   output logic master_reset_n_out // Master reset, active low
);
   // Twelve system cycles span three reference periods
   localparam logic [3:0] MR_LEN = 4'hC;
   logic [1:0] cnt_reg;
   logic [3:0] mr_cnt_reg;
   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
      begin
         cnt_reg <= 2'h0;
         mr_cnt_reg <= MR_LEN;
      end
      else
      begin
         cnt_reg <= cnt_reg + 2'h1;
         if (mr_request_in)
            mr_cnt_reg <= MR_LEN;
         else if (mr_cnt_reg != 4'h0)
            mr_cnt_reg <= mr_cnt_reg - 4'h1;
      end
   end
   // A stopped input sits low, as a dead source would
   assign ref_clk_out = {4{cnt_reg[1]}} & ~ref_stop_in;
   assign vco_clk_out = cnt_reg[0];
   assign master_reset_n_out = (mr_cnt_reg == 4'h0);
endmodule : board_ctrl_model

// >>> dv/redundant_clock_switch_control_status_test.sv
/*
 * Self-checking bench for the clock switch control and status block.
 * Assumes the board model supplies reference clocks and master reset pulses.
 */
`timescale 1ns/1ps
module redundant_clock_switch_control_status_test;
   import clk_switch_pkg::*;
   logic mclk_in, nrst_in, loop_bypass_in, alarm_clear_n_in, preset_select_in;
   logic eeprom_boot_select_in, external_loop_select_in, global_output_gate_in;
   logic pll_unlocked_in, mr_request, vco_clk, master_reset_n;
   logic [3:0] ref_clk, ref_stop, clk_qualify_in, clk_health_out;
   logic [MODE_W-1:0] switch_mode_in;
   logic clk_out, out_enable_out, pll_active_out, ext_feedback_out, divider_reset_out;
   logic preset_load_out, eeprom_boot_start_out, switch_busy_n_out, lock_n_out;
   logic status_change_n_out, status_change_oe_out;
   logic [1:0] cfg_source_out, ref_select_out;
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;
   board_ctrl_model board_ctrl_model_i (.mclk_in(mclk_in), .nrst_in(nrst_in),
      .ref_stop_in(ref_stop), .mr_request_in(mr_request), .ref_clk_out(ref_clk),
      .vco_clk_out(vco_clk), .master_reset_n_out(master_reset_n));
   clk_switch_ctrl clk_switch_ctrl_i (.mclk_in(mclk_in), .nrst_in(nrst_in),
      .ref_clk_in(ref_clk), .clk_qualify_in(clk_qualify_in),
      .loop_bypass_in(loop_bypass_in), .alarm_clear_n_in(alarm_clear_n_in),
      .master_reset_n_in(master_reset_n), .preset_select_in(preset_select_in),
      .eeprom_boot_select_in(eeprom_boot_select_in),
      .external_loop_select_in(external_loop_select_in),
      .global_output_gate_in(global_output_gate_in), .pll_unlocked_in(pll_unlocked_in),
      .vco_clk_in(vco_clk), .switch_mode_in(switch_mode_in), .clk_out(clk_out),
      .out_enable_out(out_enable_out), .pll_active_out(pll_active_out),
      .ext_feedback_out(ext_feedback_out), .divider_reset_out(divider_reset_out),
      .preset_load_out(preset_load_out), .eeprom_boot_start_out(eeprom_boot_start_out),
      .cfg_source_out(cfg_source_out), .ref_select_out(ref_select_out),
      .clk_health_out(clk_health_out), .switch_busy_n_out(switch_busy_n_out),
      .lock_n_out(lock_n_out), .status_change_n_out(status_change_n_out),
      .status_change_oe_out(status_change_oe_out));
   initial
   begin
      mclk_in = 1'b0;
      forever #2 mclk_in = ~mclk_in;
   end
   task automatic chk_bit(input logic act, input logic exp);
      num_checks++;
      if (act !== exp)
      begin
         errors++;
         $display("FAIL t=%0t act=%h exp=%h", $time, act, exp);
      end
   endtask : chk_bit
   task automatic chk_vec(input logic [3:0] act, input logic [3:0] exp);
      num_checks++;
      if (act !== exp)
      begin
         errors++;
         $display("FAIL t=%0t act=%h exp=%h", $time, act, exp);
      end
   endtask : chk_vec
   task automatic stop_test();
      if (errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   // Let n rising edges pass, then sample settled outputs
   task automatic look(input int n);
      repeat (n) @(posedge mclk_in);
      @(negedge mclk_in);
   endtask : look
   always @(posedge mclk_in)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         errors++;
         stop_test();
      end
   end
   task automatic test_missing();
      look(1);
      chk_vec(clk_health_out, 4'hF);
      @(posedge mclk_in);
      ref_stop <= 4'h4;
      look(60);
      chk_vec(clk_health_out, 4'hB);
      chk_bit(status_change_n_out, 1'b0);
      chk_bit(status_change_oe_out, 1'b1);
      @(posedge mclk_in);
      ref_stop <= 4'h0;
      look(20);
      chk_bit(status_change_n_out, 1'b0);
   endtask : test_missing
   task automatic test_auto_switch();
      int n;
      @(posedge mclk_in);
      clk_qualify_in <= 4'hD;
      switch_mode_in <= 3'h4;
      look(10);
      chk_vec({2'h0, ref_select_out}, 4'h0);
      @(posedge mclk_in);
      ref_stop <= 4'h1;
      n = 0;
      while (switch_busy_n_out !== 1'b0 && n < 80)
      begin
         look(0);
         n++;
      end
      chk_bit(switch_busy_n_out, 1'b0);
      chk_vec({2'h0, ref_select_out}, 4'h3);
      n = 0;
      while (switch_busy_n_out === 1'b0 && n < 200)
      begin
         look(0);
         n++;
      end
      chk_bit(n >= SWITCH_CYCLES - 2 && n <= SWITCH_CYCLES + 2, 1'b1);
      @(posedge mclk_in);
      ref_stop <= 4'h0;
   endtask : test_auto_switch
   task automatic test_bypass_clear();
      logic seen;
      @(posedge mclk_in);
      loop_bypass_in <= 1'b1;
      external_loop_select_in <= 1'b1;
      ref_stop <= 4'h8;
      look(60);
      chk_bit(pll_active_out, 1'b0);
      chk_bit(ext_feedback_out, 1'b1);
      chk_bit(clk_health_out[3], 1'b1);
      chk_vec({2'h0, ref_select_out}, 4'h3);
      @(posedge mclk_in);
      ref_stop <= 4'h0;
      alarm_clear_n_in <= 1'b0;
      seen = 1'b0;
      repeat (8)
      begin
         look(0);
         if (clk_health_out === 4'h0)
            seen = 1'b1;
      end
      chk_bit(seen, 1'b1);
      chk_vec({2'h0, ref_select_out}, 4'h0);
      @(posedge mclk_in);
      loop_bypass_in <= 1'b0;
      external_loop_select_in <= 1'b0;
      switch_mode_in <= 3'h0;
      look(20);
      chk_vec(clk_health_out, 4'hF);
      chk_bit(pll_active_out, 1'b1);
      chk_bit(ext_feedback_out, 1'b0);
      @(posedge mclk_in);
      alarm_clear_n_in <= 1'b1;
      look(5);
      chk_bit(status_change_n_out, 1'b1);
   endtask : test_bypass_clear
   task automatic test_lock_fail();
      @(posedge mclk_in);
      switch_mode_in <= 3'h4;
      clk_qualify_in <= 4'h0;
      pll_unlocked_in <= 1'b1;
      look(10);
      chk_bit(lock_n_out, 1'b1);
      chk_bit(switch_busy_n_out, 1'b0);
      chk_bit(status_change_n_out, 1'b0);
      @(posedge mclk_in);
      pll_unlocked_in <= 1'b0;
      clk_qualify_in <= 4'hF;
      look(SWITCH_CYCLES + 10);
      chk_bit(switch_busy_n_out, 1'b1);
      chk_bit(lock_n_out, 1'b0);
      chk_bit(status_change_n_out, 1'b1);
   endtask : test_lock_fail
   task automatic test_cfg(input logic preset, input logic [3:0] src);
      logic seen;
      @(posedge mclk_in);
      preset_select_in <= preset;
      eeprom_boot_select_in <= ~preset;
      mr_request <= 1'b1;
      @(posedge mclk_in);
      mr_request <= 1'b0;
      look(6);
      chk_bit(divider_reset_out, 1'b1);
      seen = 1'b0;
      repeat (20)
      begin
         look(0);
         if ((preset ? preset_load_out : eeprom_boot_start_out) === 1'b1)
            seen = 1'b1;
      end
      chk_bit(seen, 1'b1);
      chk_vec({2'h0, cfg_source_out}, src);
      chk_bit(divider_reset_out, 1'b0);
   endtask : test_cfg
   task automatic test_gate();
      logic seen;
      @(posedge mclk_in);
      switch_mode_in <= 3'h2;
      global_output_gate_in <= 1'b0;
      look(10);
      chk_vec({2'h0, ref_select_out}, 4'h2);
      chk_bit(out_enable_out, 1'b0);
      chk_bit(clk_out, 1'b0);
      @(posedge mclk_in);
      global_output_gate_in <= 1'b1;
      look(10);
      chk_bit(out_enable_out, 1'b1);
      seen = 1'b0;
      repeat (4)
      begin
         look(0);
         if (clk_out === 1'b1)
            seen = 1'b1;
      end
      chk_bit(seen, 1'b1);
   endtask : test_gate
   initial
   begin
      nrst_in = 1'b0;
      loop_bypass_in = 1'b0;
      alarm_clear_n_in = 1'b1;
      preset_select_in = 1'b0;
      eeprom_boot_select_in = 1'b0;
      external_loop_select_in = 1'b0;
      global_output_gate_in = 1'b1;
      pll_unlocked_in = 1'b0;
      mr_request = 1'b0;
      ref_stop = 4'h0;
      clk_qualify_in = 4'hF;
      switch_mode_in = 3'h0;
      look(3);
      chk_vec(clk_health_out, 4'h0);
      chk_bit(switch_busy_n_out & lock_n_out & status_change_n_out, 1'b1);
      chk_bit(divider_reset_out, 1'b1);
      @(posedge mclk_in);
      nrst_in <= 1'b1;
      look(40);
      test_missing();
      test_auto_switch();
      test_bypass_clear();
      test_lock_fail();
      test_cfg(1'b1, 4'h1);
      test_cfg(1'b0, 4'h2);
      test_gate();
      stop_test();
   end
endmodule : redundant_clock_switch_control_status_test

// >>> verilog/clk_monitor_if.sv
/*
 * Carrier between the switch control and one missing-clock detector.
 * Assumes the clock level is already synchronised to mclk_in.
 */
`timescale 1ns/1ps
interface clk_monitor_if;
   logic clk_level;
   logic watch_en;
   logic missing;
   modport ctrl (output clk_level, output watch_en, input missing);
   modport det (input clk_level, input watch_en, output missing);
endinterface : clk_monitor_if

// >>> verilog/clk_switch_ctrl.sv
/*
 * Control and status logic of a four-input redundant clock switch.
 * Assumes pins are asynchronous and the switch mode comes from
 * configuration logic on mclk_in.
 */
`timescale 1ns/1ps
module clk_switch_ctrl
   import clk_switch_pkg::*;
(
   input wire logic mclk_in, // 250 MHz system clock
   input wire logic nrst_in, // Synchronous reset, active low
   input wire logic [clk_switch_pkg::NUM_INPUTS-1:0] ref_clk_in, // Reference clocks
   input wire logic [clk_switch_pkg::NUM_INPUTS-1:0] clk_qualify_in, // Input qualifiers
   input wire logic loop_bypass_in, // Static test mode
   input wire logic alarm_clear_n_in, // Alarm clear, active low
   input wire logic master_reset_n_in, // Master reset, active low
   input wire logic preset_select_in, // Use built-in defaults
   input wire logic eeprom_boot_select_in, // Boot from serial memory
   input wire logic external_loop_select_in, // External feedback path
   input wire logic global_output_gate_in, // Enable for the clock output
   input wire logic pll_unlocked_in, // From PLL, high when unlocked
   input wire logic vco_clk_in, // Oscillator output
   input wire logic [clk_switch_pkg::MODE_W-1:0] switch_mode_in, // Configured switch mode
   output logic clk_out, // Gated output clock
   output logic out_enable_out, // Output drivers enabled
   output logic pll_active_out, // PLL in the loop
   output logic ext_feedback_out, // External feedback chosen
   output logic divider_reset_out, // Reset of generators and dividers
   output logic preset_load_out, // Pulse: load default configuration
   output logic eeprom_boot_start_out, // Pulse: start memory boot
   output logic [1:0] cfg_source_out, // Last configuration source
   output logic [clk_switch_pkg::SEL_W-1:0] ref_select_out, // Selected input
   output logic [clk_switch_pkg::NUM_INPUTS-1:0] clk_health_out, // High when valid
   output logic switch_busy_n_out, // Low while switching
   output logic lock_n_out, // High when unlocked
   output logic status_change_n_out, // Low on status change
   output logic status_change_oe_out // Open-drain pull-down enable
);
   import clk_switch_pkg::*;

   logic [PIN_W-1:0] sync1_reg;
   logic [PIN_W-1:0] sync2_reg;
   logic alarm_prev_reg;
   logic mrn_prev_reg;
   logic [NUM_INPUTS-1:0] fail_reg;
   logic [NUM_INPUTS-1:0] health_reg;
   logic [SEL_W-1:0] sel_reg;
   logic [SEL_W-1:0] sel_next;
   logic [MODE_W-1:0] mode_prev_reg;
   switch_state_e state_reg;
   switch_state_e state_next;
   logic [CNT_W-1:0] busy_cnt_reg;
   logic busy_n_reg;
   logic lock_n_reg;
   logic stat_n_reg;
   logic stat_oe_reg;
   logic gate_reg;
   logic clk_reg;
   logic pll_on_reg;
   logic extfb_reg;
   logic divrst_reg;
   logic preset_reg;
   logic boot_reg;
   cfg_source_e cfg_reg;
   logic [NUM_INPUTS-1:0] missing;

   // Synchronised pin views
   wire [NUM_INPUTS-1:0] ref_s = sync2_reg[P_REF +: NUM_INPUTS];
   wire [NUM_INPUTS-1:0] qual_s = sync2_reg[P_QUAL +: NUM_INPUTS];
   wire bypass_s = sync2_reg[P_BYPASS];
   wire alarm_n_s = sync2_reg[P_ALARMN];
   wire mrn_s = sync2_reg[P_MRN];
   wire preset_s = sync2_reg[P_PRESET];
   wire boot_s = sync2_reg[P_BOOT];
   wire extfb_s = sync2_reg[P_EXTFB];
   wire gate_s = sync2_reg[P_GATE];
   wire unlock_s = sync2_reg[P_UNLOCK];
   wire vco_s = sync2_reg[P_VCO];

   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
      begin
         sync1_reg <= SYNC_RST;
         sync2_reg <= SYNC_RST;
      end
      else
      begin
         sync1_reg <= {ref_clk_in, clk_qualify_in, loop_bypass_in, alarm_clear_n_in,
                       master_reset_n_in, preset_select_in, eeprom_boot_select_in,
                       external_loop_select_in, global_output_gate_in, pll_unlocked_in,
                       vco_clk_in};
         sync2_reg <= sync1_reg;
      end
   end

   // One detector per reference input, idle during bypass
   clk_monitor_if mon [NUM_INPUTS] ();
   generate
      for (genvar i = 0; i < NUM_INPUTS; i++)
      begin : g_mon
         assign mon[i].clk_level = ref_s[i];
         assign mon[i].watch_en = !bypass_s;
         assign missing[i] = mon[i].missing;
         missing_clock_detector #(
            .TIMEOUT(MISSING_CYCLES)
         ) u_det (
            .mclk_in(mclk_in),
            .nrst_in(nrst_in),
            .mon(mon[i].det)
         );
      end
   endgenerate

   // Event decoding
   wire clear_evt = alarm_prev_reg && !alarm_n_s;
   wire mr_release = !mrn_prev_reg && mrn_s;
   wire auto_mode = switch_mode_in[MODE_AUTO_BIT];
   wire [SEL_W-1:0] primary = switch_mode_in[SEL_W-1:0];
   wire mode_changed = switch_mode_in != mode_prev_reg;
   wire [NUM_INPUTS-1:0] qualified = qual_s & health_reg & ~missing & ~fail_reg;
   wire ref_failed = !qualified[sel_reg];
   wire monitor_on = !bypass_s && mrn_s;

   // Next qualified input after the current one, round robin
   function automatic logic [SEL_W:0] next_qualified(input logic [NUM_INPUTS-1:0] q,
                                                     input logic [SEL_W-1:0] cur);
      logic [SEL_W:0] res;
      logic [SEL_W-1:0] cand;
      res = {1'b0, cur};
      for (int k = NUM_INPUTS - 1; k >= 1; k--)
      begin
         cand = cur + SEL_W'(k);
         if (q[cand])
            res = {1'b1, cand};
      end
      return res;
   endfunction : next_qualified

   wire [SEL_W:0] nq = next_qualified(qualified, sel_reg);
   wire found = nq[SEL_W];
   wire start_switch = monitor_on && auto_mode && state_reg == SW_IDLE && ref_failed
                       && !clear_evt && !mode_changed;
   wire busy_done = busy_cnt_reg >= CNT_W'(SWITCH_CYCLES - 1);

   always_comb
   begin
      sel_next = sel_reg;
      state_next = state_reg;
      if (clear_evt)
         sel_next = SEL_RST;
      else if (!mrn_s)
         state_next = SW_IDLE;
      else if (!auto_mode)
      begin
         if (!bypass_s)
            sel_next = primary;
         state_next = SW_IDLE;
      end
      else if (bypass_s)
         state_next = SW_IDLE;
      else if (mode_changed && qualified[primary])
         sel_next = primary;
      else
      begin
         case (state_reg)
            SW_IDLE:
               if (start_switch)
               begin
                  if (found)
                  begin
                     sel_next = nq[SEL_W-1:0];
                     state_next = SW_BUSY;
                  end
                  else
                     state_next = SW_STALL;
               end
            SW_BUSY:
               if (busy_done)
                  state_next = SW_IDLE;
            SW_STALL:
               if (found)
               begin
                  sel_next = nq[SEL_W-1:0];
                  state_next = SW_BUSY;
               end
               else if (!ref_failed)
                  state_next = SW_IDLE;
            default:
               state_next = SW_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
      begin
         sel_reg <= SEL_RST;
         state_reg <= SW_IDLE;
         busy_cnt_reg <= '0;
         mode_prev_reg <= '0;
         alarm_prev_reg <= 1'b1;
         mrn_prev_reg <= 1'b1;
      end
      else
      begin
         sel_reg <= sel_next;
         state_reg <= state_next;
         busy_cnt_reg <= (state_next == SW_BUSY && state_reg == SW_BUSY) ?
                         busy_cnt_reg + 1'b1 : '0;
         mode_prev_reg <= switch_mode_in;
         alarm_prev_reg <= alarm_n_s;
         mrn_prev_reg <= mrn_s;
      end
   end

   // Sticky alarms: a new failure wins over a clear in the same cycle
   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
      begin
         fail_reg <= FLAGS_CLEAR;
         health_reg <= FLAGS_CLEAR;
      end
      else
      begin
         fail_reg <= (clear_evt ? FLAGS_CLEAR : fail_reg) | missing;
         health_reg <= clear_evt ? FLAGS_CLEAR : ~missing & ~fail_reg;
      end
   end

   // Status outputs
   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
      begin
         busy_n_reg <= 1'b1;
         lock_n_reg <= 1'b1;
         stat_n_reg <= 1'b1;
         stat_oe_reg <= 1'b0;
      end
      else
      begin
         busy_n_reg <= state_next == SW_IDLE;
         lock_n_reg <= unlock_s;
         stat_n_reg <= !((|fail_reg) || unlock_s);
         stat_oe_reg <= (|fail_reg) || unlock_s;
      end
   end

   // Output clock source, gate and loop controls
   wire src_clk = bypass_s ? ref_s[sel_reg] : vco_s;
   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
      begin
         gate_reg <= 1'b0;
         clk_reg <= 1'b0;
         pll_on_reg <= 1'b1;
         extfb_reg <= 1'b0;
         divrst_reg <= 1'b1;
      end
      else
      begin
         if (!src_clk)
            gate_reg <= gate_s;
         clk_reg <= src_clk && gate_reg && mrn_s;
         pll_on_reg <= !bypass_s;
         extfb_reg <= extfb_s;
         divrst_reg <= !mrn_s;
      end
   end

   // Configuration source chosen at master reset release
   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
      begin
         preset_reg <= 1'b0;
         boot_reg <= 1'b0;
         cfg_reg <= CFG_SERIAL;
      end
      else
      begin
         preset_reg <= mr_release && preset_s;
         boot_reg <= mr_release && boot_s && !preset_s;
         if (mr_release)
            cfg_reg <= preset_s ? CFG_PRESET : (boot_s ? CFG_EEPROM : CFG_SERIAL);
      end
   end

   assign clk_out = clk_reg;
   assign out_enable_out = gate_reg;
   assign pll_active_out = pll_on_reg;
   assign ext_feedback_out = extfb_reg;
   assign divider_reset_out = divrst_reg;
   assign preset_load_out = preset_reg;
   assign eeprom_boot_start_out = boot_reg;
   assign cfg_source_out = cfg_reg;
   assign ref_select_out = sel_reg;
   assign clk_health_out = health_reg;
   assign switch_busy_n_out = busy_n_reg;
   assign lock_n_out = lock_n_reg;
   assign status_change_n_out = stat_n_reg;
   assign status_change_oe_out = stat_oe_reg;

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!nrst_in);

   sequence mr_release_s;
      !mrn_s ##1 mrn_s;
   endsequence
   sequence clear_pulse_s;
      alarm_n_s ##1 !alarm_n_s;
   endsequence

   chk_bypass_freeze: assert property (
      (bypass_s && !clear_evt) |=> sel_reg == $past(sel_reg) && busy_n_reg)
      else $error("selection moved during bypass");
   chk_clear_once: assert property (
      clear_evt |=> !clear_evt [*2])
      else $error("alarm clear fired twice for one pulse");
   chk_clear_flags: assert property (
      clear_pulse_s |=> health_reg == FLAGS_CLEAR && sel_reg == SEL_RST)
      else $error("clear did not zero health and selection");
   chk_busy_on_switch: assert property (
      (start_switch && found) |=> !busy_n_reg ##1 !switch_busy_n_out)
      else $error("busy not low after switch start");
   chk_stall_busy: assert property (
      (state_reg == SW_STALL && state_next == SW_STALL) |=> !busy_n_reg)
      else $error("busy released with no qualified input");
   chk_status_change: assert property (
      (|fail_reg) |=> !stat_n_reg && stat_oe_reg)
      else $error("status change not asserted on alarm");
   chk_gate_low_src: assert property (
      $changed(gate_reg) |-> !$past(src_clk))
      else $error("output gate changed while clock high");
   chk_preset_load: assert property (
      (mr_release_s ##0 preset_s) |=> preset_load_out)
      else $error("preset not loaded at master reset release");
   chk_divider_reset: assert property (
      !mrn_s |=> divider_reset_out ##0 !clk_reg)
      else $error("dividers not reset during master reset");
   chk_feedback_sel: assert property (
      $stable(extfb_s) [*2] |-> ext_feedback_out == extfb_s)
      else $error("feedback select not followed");
   chk_manual_select: assert property (
      (!auto_mode && !bypass_s && !clear_evt) |=> sel_reg == $past(primary))
      else $error("manual selection not applied");
endmodule : clk_switch_ctrl

// >>> verilog/clk_switch_pkg.sv
/*
 * Constants for the redundant clock switch control and status block.
 * Assumes a single 250 MHz system clock; all pin inputs are asynchronous.
 */
package clk_switch_pkg;
   localparam int NUM_INPUTS = 4;
   localparam int SEL_W = 2;
   localparam int MODE_W = 3;
   localparam int MODE_AUTO_BIT = 2;
   localparam int CLK_PERIOD_PS = 4000;
   localparam int MISSING_TIME_NS = 200;
   localparam int MISSING_CYCLES = (MISSING_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int SWITCH_TIME_NS = 400;
   localparam int SWITCH_CYCLES = (SWITCH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 12;
   // Positions in the synchronised pin vector
   localparam int P_VCO = 0;
   localparam int P_UNLOCK = 1;
   localparam int P_GATE = 2;
   localparam int P_EXTFB = 3;
   localparam int P_BOOT = 4;
   localparam int P_PRESET = 5;
   localparam int P_MRN = 6;
   localparam int P_ALARMN = 7;
   localparam int P_BYPASS = 8;
   localparam int P_QUAL = 9;
   localparam int P_REF = 13;
   localparam int PIN_W = 17;
   localparam logic [PIN_W-1:0] SYNC_RST = 17'h000C2;
   localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
   localparam logic [NUM_INPUTS-1:0] FLAGS_CLEAR = 4'h0;
   typedef enum logic [1:0] {
      SW_IDLE = 2'b00,
      SW_BUSY = 2'b01,
      SW_STALL = 2'b11
   } switch_state_e;
   typedef enum logic [1:0] {
      CFG_SERIAL = 2'b00,
      CFG_PRESET = 2'b01,
      CFG_EEPROM = 2'b10
   } cfg_source_e;
endpackage : clk_switch_pkg

// >>> verilog/missing_clock_detector.sv
/*
 * Missing-clock detector for one reference input.
 * Assumes a synchronised clock level and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module missing_clock_detector
   import clk_switch_pkg::*;
#(
   parameter int TIMEOUT = MISSING_CYCLES
)(
   input wire logic mclk_in, // System clock
   input wire logic nrst_in, // Synchronous reset, active low
   clk_monitor_if.det mon // Level in, missing flag out
);
   logic prev_reg;
   logic [CNT_W-1:0] quiet_reg;
   logic missing_reg;
   wire edge_seen = mon.clk_level ^ prev_reg;
   wire timed_out = quiet_reg >= CNT_W'(TIMEOUT);

   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
      begin
         prev_reg <= 1'b0;
         quiet_reg <= '0;
         missing_reg <= 1'b0;
      end
      else
      begin
         prev_reg <= mon.clk_level;
         if (!mon.watch_en || edge_seen)
            quiet_reg <= '0;
         else if (!timed_out)
            quiet_reg <= quiet_reg + 1'b1;
         missing_reg <= mon.watch_en && timed_out && !edge_seen;
      end
   end
   assign mon.missing = missing_reg;

   chk_missing_needs_quiet: assert property (@(posedge mclk_in) disable iff (!nrst_in)
      $rose(missing_reg) |-> $past(quiet_reg) >= CNT_W'(TIMEOUT))
      else $error("missing flag raised before timeout");
endmodule : missing_clock_detector
